// ==== id_and_wait_trap_decoder.sv ====
// Trap decision for id register groups and wait-for-event
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module id_and_wait_trap_decoder
    import trap_dec_pkg::*;
#(
    parameter bit SUPPORT_32BIT = 1'b1,     // 32-bit execution present
    parameter bit HOST_EXT = 1'b1,          // Host extensions present
    parameter bit WAIT_TIMEOUT = 1'b1,      // Timeout wait present
    parameter bit BYTECODE_USER_RAZ = 1'b1, // User bytecode id reads zero
    parameter int COUNT_W = 16              // Trap counter width
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Decode side
    input wire logic hyp_enabled_i,
    input wire access_t acc_i,
    // Exception entry side
    output logic hyp_trap_o,
    output logic [5:0] class_code_o,
    output logic kern_trap_o,
    output logic undef_o
);

    // Writable control bits, only these are stored
    localparam logic [31:0] CTRL_MASK = (32'h1 << G2_BIT) |
        (32'h1 << G1_BIT) | (32'h1 << WE_BIT) |
        (SUPPORT_32BIT ? (32'h1 << G0_BIT) : 32'h0);
    localparam logic [31:0] HOST_MASK = (32'h1 << E2H_BIT) |
        (32'h1 << TGE_BIT);

    // Bus state and registers
    bus_state_t bus_state_reg; // Slave handshake state
    bus_state_t bus_state_next;
    logic [31:0] ctrl_reg;     // Trap control bits
    logic [31:0] ctrl_next;
    logic [31:0] host_reg;     // Host-in-hyp and general trap bits
    logic [31:0] host_next;
    logic [31:0] rdata_reg;    // Read data, loaded while waiting
    logic [31:0] rdata_next;
    logic [5:0] last_ec_reg;   // Class of the last outcome, zero for kernel or undefined
    logic last_kern_reg;       // Last outcome was a kernel trap
    logic last_undef_reg;      // Last outcome was undefined
    logic [COUNT_W-1:0] trap_cnt_reg; // Hyp traps taken

    // Classifier results
    logic g2_hit;
    logic g1_hit;
    logic g0_hit;
    logic [5:0] g0_ec;
    logic cls_kern;
    logic cls_undef;
    logic wait_ok;
    logic wait_kern;
    verdict_t verdict;

    // Access decode
    id_access_classifier #(
        .BYTECODE_USER_RAZ(BYTECODE_USER_RAZ)
    ) u_classifier (
        .acc_i(acc_i),
        .g2_hit_o(g2_hit),
        .g1_hit_o(g1_hit),
        .g0_hit_o(g0_hit),
        .g0_ec_o(g0_ec),
        .kern_hit_o(cls_kern),
        .undef_hit_o(cls_undef)
    );

    // Wait qualification
    wait_event_qualifier #(
        .WAIT_TIMEOUT(WAIT_TIMEOUT)
    ) u_wait (
        .acc_i(acc_i),
        .hyp_ok_o(wait_ok),
        .kern_hit_o(wait_kern)
    );

    // Bus request decode
    wire bus_req = avs_read_i || avs_write_i;
    wire in_ack = bus_state_reg == BUS_ACK;
    wire wr_take = avs_write_i && in_ack;
    wire sel_ctrl = avs_address_i == CTRL_OFFSET;
    wire sel_host = avs_address_i == HOST_OFFSET;
    wire sel_status = avs_address_i == STATUS_OFFSET;

    // Status word seen by software
    wire [31:0] status_word = (32'(last_ec_reg) << ST_EC_LSB) |
        (32'(last_kern_reg) << ST_KERN_BIT) |
        (32'(last_undef_reg) << ST_UNDEF_BIT) |
        (32'(trap_cnt_reg) << ST_CNT_LSB);

    // Direct reads return the stored bits even when masked
    wire [31:0] rd_mux = sel_ctrl ? ctrl_reg :
        sel_host ? host_reg :
        sel_status ? status_word : 32'h0000_0000;

    // One wait state on every access keeps read data registered
    assign avs_waitrequest_o = bus_req && !in_ack;
    assign avs_readdata_o = rdata_reg;

    assign bus_state_next = (bus_req && !in_ack) ? BUS_ACK : BUS_IDLE;
    assign rdata_next = (avs_read_i && !in_ack) ? rd_mux : rdata_reg;
    // Unmapped writes are dropped; group-0 bit stays zero without 32-bit
    assign ctrl_next = (wr_take && sel_ctrl) ?
        (merge_bytes(ctrl_reg, avs_writedata_i, avs_byteenable_i) &
        CTRL_MASK) : ctrl_reg;
    assign host_next = (wr_take && sel_host) ?
        (merge_bytes(host_reg, avs_writedata_i, avs_byteenable_i) &
        HOST_MASK) : host_reg;

    // Bus and control registers
    // Controls come out of reset at a fixed value, and the trap logic
    // uses that value directly until software writes them
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bus_state_reg <= BUS_IDLE;
            ctrl_reg <= CTRL_RESET;
            host_reg <= HOST_RESET;
            rdata_reg <= 32'h0000_0000;
        end else begin
            bus_state_reg <= bus_state_next;
            ctrl_reg <= ctrl_next;
            host_reg <= host_next;
            rdata_reg <= rdata_next;
        end
    end

    // Effective controls
    wire trap_general_exceptions = host_reg[TGE_BIT];
    wire vhe_host = HOST_EXT && host_reg[E2H_BIT] && trap_general_exceptions;
    wire eff_g2 = ctrl_reg[G2_BIT] && !vhe_host;
    wire eff_g1 = ctrl_reg[G1_BIT] && !trap_general_exceptions;
    wire eff_g0 = ctrl_reg[G0_BIT] && !vhe_host;
    wire eff_we = ctrl_reg[WE_BIT] && !vhe_host;

    // Hyp trap only when the hyp level is enabled
    wire t_g2 = hyp_enabled_i && eff_g2 && g2_hit;
    wire t_g1 = hyp_enabled_i && eff_g1 && g1_hit;
    wire t_g0 = hyp_enabled_i && eff_g0 && g0_hit;
    wire t_we = hyp_enabled_i && eff_we && wait_ok;
    wire any_kern = cls_kern || wait_kern;

    // Priority: undefined, then kernel trap, then hyp trap
    always_comb begin
        verdict = '{hyp: 1'b0, kern: 1'b0, undef: 1'b0, ec: EC_NONE};
        if (cls_undef) begin
            verdict.undef = 1'b1;
        end else if (any_kern) begin
            verdict.kern = 1'b1;
        end else if (t_g2 || t_g1) begin
            verdict.hyp = 1'b1;
            verdict.ec = ec_by_width(acc_i.is64);
        end else if (t_g0) begin
            verdict.hyp = 1'b1;
            verdict.ec = g0_ec;
        end else if (t_we) begin
            verdict.hyp = 1'b1;
            verdict.ec = EC_WAIT;
        end
    end

    // Answer in the cycle the instruction resolves, no pipeline
    assign hyp_trap_o = verdict.hyp;
    assign class_code_o = verdict.ec;
    assign kern_trap_o = verdict.kern;
    assign undef_o = verdict.undef;

    // Status capture of each outcome
    // The counter wraps; software samples it as a free-running tally
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            last_ec_reg <= EC_NONE;
            last_kern_reg <= 1'b0;
            last_undef_reg <= 1'b0;
            trap_cnt_reg <= '0;
        end else if (verdict.hyp || verdict.kern || verdict.undef) begin
            last_ec_reg <= verdict.ec;
            last_kern_reg <= verdict.kern;
            last_undef_reg <= verdict.undef;
            if (verdict.hyp) begin
                trap_cnt_reg <= trap_cnt_reg + 1'b1;
            end
        end
    end

    // Checks
    // Kernel 64-bit read of a cache id register with group 2 live
    sequence s_k64_cache_rd;
        acc_i.valid && acc_i.lvl == LVL_KERNEL && acc_i.is64 && acc_i.rd &&
        acc_i.sel inside {REG_CACHE_TYPE, REG_CACHE_SIZE_ID,
        REG_CACHE_LEVEL, REG_CACHE_SIZE_SEL};
    endsequence
    sequence s_g2_live;
        hyp_enabled_i && ctrl_reg[G2_BIT] && !vhe_host;
    endsequence
    // Bus write to the control register accepted with byte lane 1 enabled
    sequence s_ctrl_write;
        avs_write_i && !avs_waitrequest_o && sel_ctrl &&
        avs_byteenable_i[1];
    endsequence

    AST_G2_K64_READ: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (s_k64_cache_rd and s_g2_live) |-> hyp_trap_o &&
        class_code_o == 6'h18)
    else $error("group 2 kernel read not trapped with 0x18");

    AST_UCT_ZERO: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        acc_i.valid && acc_i.lvl == LVL_USER && acc_i.is64 && acc_i.rd &&
        acc_i.sel == REG_CACHE_TYPE && !acc_i.uct_nonzero |->
        kern_trap_o && !hyp_trap_o)
    else $error("user cache type read with access off not to kernel");

    AST_SEL_WRITE: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_g2_live and (acc_i.valid && acc_i.lvl == LVL_KERNEL &&
        acc_i.wr && acc_i.sel == REG_CACHE_SIZE_SEL) |-> hyp_trap_o &&
        class_code_o == (acc_i.is64 ? 6'h18 : 6'h03))
    else $error("size select write class wrong");

    AST_G2_K32_READ: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_g2_live and (acc_i.valid && acc_i.lvl == LVL_KERNEL &&
        !acc_i.is64 && acc_i.rd && acc_i.sel == REG_CACHE_SIZE_ID2) |->
        hyp_trap_o && class_code_o == 6'h03)
    else $error("group 2 32-bit read not trapped with 0x03");

    AST_HYP_OFF: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        !hyp_enabled_i || ctrl_reg[17:14] == 4'h0 |-> !hyp_trap_o)
    else $error("hyp trap with level disabled or controls clear");

    AST_VHE_MASK: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        HOST_EXT && host_reg[E2H_BIT] && host_reg[TGE_BIT] |->
        !hyp_trap_o)
    else $error("trap taken while host controls mask it");

    AST_G1_READ: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        hyp_enabled_i && ctrl_reg[G1_BIT] && !trap_general_exceptions && acc_i.valid &&
        acc_i.lvl == LVL_KERNEL && acc_i.rd && acc_i.sel == REG_REVISION
        |-> hyp_trap_o && class_code_o == (acc_i.is64 ? 6'h18 : 6'h03))
    else $error("group 1 revision read not trapped");

    AST_TGE_G1: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        trap_general_exceptions && acc_i.sel inside {REG_REVISION, REG_AUX, REG_MATRIX,
        REG_TCM_TYPE, REG_TLB_TYPE} |-> !hyp_trap_o)
    else $error("group 1 acted with general traps set");

    AST_G0_RESERVED: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_ctrl_write |=> (ctrl_reg[G0_BIT] == (SUPPORT_32BIT &&
        $past(avs_writedata_i[G0_BIT]))))
    else $error("group 0 bit stored wrongly");

    AST_BYTECODE: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        hyp_enabled_i && eff_g0 && acc_i.valid &&
        acc_i.lvl == LVL_KERNEL && !acc_i.is64 && acc_i.rd &&
        acc_i.sel == REG_BYTECODE |-> hyp_trap_o && class_code_o == 6'h05)
    else $error("bytecode id read not trapped with 0x05");

    AST_FP_MOVE: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        hyp_enabled_i && eff_g0 && acc_i.valid &&
        acc_i.lvl == LVL_KERNEL && !acc_i.is64 && acc_i.rd &&
        acc_i.fp_move && acc_i.sel == REG_FP_SYSTEM |->
        hyp_trap_o && class_code_o == 6'h08)
    else $error("fp id move not trapped with 0x08");

    AST_FP_WRITE: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        acc_i.valid && acc_i.wr && !acc_i.rd &&
        acc_i.sel == REG_FP_SYSTEM |-> !hyp_trap_o)
    else $error("fp id write was trapped");

    AST_UNDEF_FIRST: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        undef_o |-> !hyp_trap_o && !kern_trap_o)
    else $error("undefined outcome not given priority");

    AST_WAIT_TRAP: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        hyp_enabled_i && eff_we && acc_i.valid && acc_i.wait_for_event_instr &&
        acc_i.would_sleep && acc_i.is64 && acc_i.lvl == LVL_KERNEL &&
        acc_i.sel == REG_NONE |-> hyp_trap_o && class_code_o == 6'h01)
    else $error("wait-for-event not trapped with 0x01");

    AST_WAIT_COND: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        acc_i.valid && !acc_i.is64 && !acc_i.cond_pass &&
        acc_i.sel == REG_NONE |-> !hyp_trap_o)
    else $error("failed condition wait was trapped");

    AST_BUS_ANSWER: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer not after one wait state");

    AST_COUNT: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        hyp_trap_o |=> trap_cnt_reg == $past(trap_cnt_reg) + 1'b1 &&
        last_ec_reg == $past(class_code_o))
    else $error("trap not recorded in status");

endmodule : id_and_wait_trap_decoder
`default_nettype wire

// ==== trap_dec_pkg.sv ====
// Constants and types shared by the id and wait trap decoder
// Contract
// - Group-2 kernel 64-bit cache id reads trap, 0x18
// - User cache-type read: hyp trap only if allowed
// - Kernel size-select writes trap, 0x18 or 0x03
// - Group-2 kernel 32-bit reads trap with 0x03
// - Zero never traps; one traps if hyp enabled
// - Host-in-hyp with general traps masks three controls
// - Group-1 kernel id reads trap, 0x18 or 0x03
// - General traps set: group-1 control ignored
// - Warm reset value unknown; nothing relies on it (here reset loads zero and the trap logic uses it)
// - Group-0 bit only with 32-bit support, else zero
// - Bytecode id reads trap with 0x05
// - Kernel fp id moves trap with 0x08
// - Fp id writes ignored, no user access
// - Undefined user bytecode read beats group-0 trap
// - Wait-for-event at user/kernel traps, 0x01
// - Timeout wait variant also trapped when present
// - Trap only if sleeping and not kernel-trapped
// - 32-bit conditional wait traps only on pass
// - Wait that would sleep forever must trap
package trap_dec_pkg;

    // Register byte offsets on the bus
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] HOST_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;
    // Control bit positions
    localparam int G2_BIT = 17;
    localparam int G1_BIT = 16;
    localparam int G0_BIT = 15;
    localparam int WE_BIT = 14;
    localparam int E2H_BIT = 0;
    localparam int TGE_BIT = 1;
    // Status fields
    localparam int ST_EC_LSB = 0;
    localparam int ST_KERN_BIT = 8;
    localparam int ST_UNDEF_BIT = 9;
    localparam int ST_CNT_LSB = 16;
    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] HOST_RESET = 32'h0000_0000;
    // Exception class codes
    localparam logic [5:0] EC_NONE = 6'h00;
    localparam logic [5:0] EC_WAIT = 6'h01;
    localparam logic [5:0] EC_COPROC = 6'h03;
    localparam logic [5:0] EC_BYTECODE = 6'h05;
    localparam logic [5:0] EC_FP_ID = 6'h08;
    localparam logic [5:0] EC_SYSREG = 6'h18;

    // Register addressed by a system register access
    typedef enum logic [3:0] {
        REG_NONE, REG_CACHE_TYPE, REG_CACHE_SIZE_ID, REG_CACHE_SIZE_ID2,
        REG_CACHE_LEVEL, REG_CACHE_SIZE_SEL, REG_REVISION, REG_AUX,
        REG_MATRIX, REG_TCM_TYPE, REG_TLB_TYPE, REG_BYTECODE,
        REG_FP_SYSTEM
    } id_reg_t;

    typedef enum logic {LVL_USER = 1'b0, LVL_KERNEL = 1'b1} level_t;

    // One resolved instruction from decode
    typedef struct packed {
        logic valid;       // Instruction resolved this cycle
        logic rd;          // Register read
        logic wr;          // Register write
        id_reg_t sel;      // Target register
        level_t lvl;       // Current level
        logic is64;        // 64-bit execution state
        logic fp_move;     // Fp system register move form
        logic wait_for_event_instr;         // Wait-for-event
        logic wait_for_event_timeout_instr;        // Wait-for-event with timeout
        logic cond_pass;   // Condition check passed
        logic would_sleep; // Would enter low power
        logic os_no_trap;  // Kernel no-trap control for waits
        logic uct_nonzero; // User cache type access allowed
    } access_t;

    // Outcome handed to exception entry
    typedef struct packed {
        logic hyp;
        logic kern;
        logic undef;
        logic [5:0] ec;
    } verdict_t;

    typedef enum logic [1:0] {BUS_IDLE = 2'b00, BUS_ACK = 2'b01} bus_state_t;

    // Class for a register trap by execution state
    function automatic logic [5:0] ec_by_width(input logic is64);
        return is64 ? EC_SYSREG : EC_COPROC;
    endfunction : ec_by_width

    // Byte-lane merge of a bus write
    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
        input logic [31:0] wdata, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

endpackage : trap_dec_pkg

// ==== id_access_classifier.sv ====
// Classifies an access into id trap groups
`timescale 1ns/1ps
`default_nettype none
module id_access_classifier
    import trap_dec_pkg::*;
#(
    parameter bit BYTECODE_USER_RAZ = 1'b1
) (
    input wire access_t acc_i,
    output logic g2_hit_o,
    output logic g1_hit_o,
    output logic g0_hit_o,
    output logic [5:0] g0_ec_o,
    output logic kern_hit_o,
    output logic undef_hit_o
);
    // Cache id family and group members
    wire cache_grp = acc_i.sel inside {REG_CACHE_TYPE, REG_CACHE_SIZE_ID,
        REG_CACHE_SIZE_ID2, REG_CACHE_LEVEL, REG_CACHE_SIZE_SEL};
    wire kern = acc_i.valid && acc_i.lvl == LVL_KERNEL;
    wire user = acc_i.valid && acc_i.lvl == LVL_USER;
    wire user_ct = user && acc_i.is64 && acc_i.rd &&
        acc_i.sel == REG_CACHE_TYPE;
    wire g1_sel = acc_i.is64 ?
        acc_i.sel inside {REG_REVISION, REG_AUX, REG_MATRIX} :
        acc_i.sel inside {REG_TCM_TYPE, REG_TLB_TYPE, REG_REVISION, REG_AUX};
    wire bc_rd = acc_i.rd && !acc_i.is64 && acc_i.sel == REG_BYTECODE;
    wire fp_acc = !acc_i.is64 && acc_i.sel == REG_FP_SYSTEM;
    // Fp writes are dropped, so only moves that read can trap
    wire fp_hit = kern && fp_acc && acc_i.fp_move && acc_i.rd;
    wire bc_hit = bc_rd && (kern || (user && BYTECODE_USER_RAZ));

    assign g2_hit_o = (kern && cache_grp && (acc_i.rd ||
        (acc_i.wr && acc_i.sel == REG_CACHE_SIZE_SEL))) ||
        (user_ct && acc_i.uct_nonzero);
    assign g1_hit_o = kern && acc_i.rd && g1_sel;
    assign g0_hit_o = bc_hit || fp_hit;
    assign g0_ec_o = fp_hit ? EC_FP_ID : EC_BYTECODE;
    assign kern_hit_o = user_ct && !acc_i.uct_nonzero;
    // Undefined user bytecode read and any 32-bit user fp id access
    assign undef_hit_o = (user && bc_rd && !BYTECODE_USER_RAZ) ||
        (user && fp_acc);
endmodule : id_access_classifier
`default_nettype wire

// ==== wait_event_qualifier.sv ====
// Decides whether a wait-for-event may be trapped
`timescale 1ns/1ps
`default_nettype none
module wait_event_qualifier
    import trap_dec_pkg::*;
#(
    parameter bit WAIT_TIMEOUT = 1'b1
) (
    input wire access_t acc_i,
    output logic hyp_ok_o,
    output logic kern_hit_o
);
    // Timeout form joins only when the feature exists
    wire is_wait = acc_i.wait_for_event_instr || (acc_i.wait_for_event_timeout_instr && WAIT_TIMEOUT);
    // 32-bit conditional form must pass its check
    wire passes = acc_i.is64 || acc_i.cond_pass;
    // A wait that would not sleep completes early and needs no trap
    wire live = acc_i.valid && is_wait && passes && acc_i.would_sleep;
    // User waits with the kernel no-trap control clear go to kernel
    assign kern_hit_o = live && acc_i.lvl == LVL_USER &&
        !acc_i.os_no_trap;
    assign hyp_ok_o = live && !kern_hit_o;
endmodule : wait_event_qualifier
`default_nettype wire

// ==== trap_decode_model.sv ====
// Behavioural model of the decode stage that feeds resolved instructions
`timescale 1ns/1ps
`default_nettype none
module trap_decode_model
    import trap_dec_pkg::*;
(
    input wire logic mclk_i,
    output access_t acc_o
);
    // Nothing resolved at time zero
    initial begin
        acc_o <= '0;
    end

    // Present one resolved instruction from the next rising edge
    task automatic issue(input access_t a);
        @(posedge mclk_i);
        acc_o <= a;
        @(negedge mclk_i);
    endtask : issue

    // Withdraw it; fields are inverted so stale values never look valid
    task automatic drop();
        access_t n;
        @(posedge mclk_i);
        n = ~acc_o;
        n.valid = 1'b0;
        acc_o <= n; // One update per edge
    endtask : drop
endmodule : trap_decode_model
`default_nettype wire

// ==== id_and_wait_trap_decoder_tb.sv ====
// Self-checking bench for the id and wait trap decoder
`timescale 1ns/1ps
`default_nettype none
module id_and_wait_trap_decoder_tb
    import trap_dec_pkg::*;
;
    logic mclk_i = 1'b0; // 10 MHz core clock
    logic sys_rst_i = 1'b1; // Reset held at start
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic hyp_en = 1'b1; // Hypervisor level enabled
    access_t acc;
    logic hyp;
    logic [5:0] ec;
    logic kern;
    logic undef;
    int bad_count = 0;
    int cmp_count = 0;
    int exp_cnt = 0; // Hyp traps expected so far
    logic [31:0] got;
    access_t a;

    // Half period of 50 ns
    always #50 mclk_i = ~mclk_i;

    trap_decode_model decoder (.mclk_i(mclk_i), .acc_o(acc));

    id_and_wait_trap_decoder dut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .hyp_enabled_i(hyp_en), .acc_i(acc),
        .hyp_trap_o(hyp), .class_code_o(ec),
        .kern_trap_o(kern), .undef_o(undef)
    );

    // One bus access; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] ad,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk_i);
        addr <= ad;
        wdata <= d;
        wr <= w;
        rd <= ~w;
        // Seen at the edge before its own updates, as the slave sees it
        do begin
            @(posedge mclk_i);
        end while (waitreq !== 1'b0);
        q = rdata; // Read data standing at the accepting edge
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    // Compare one value and count it
    task automatic cmp(input logic [31:0] g, input logic [31:0] e,
        input string m);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : cmp

    // Build a resolved register access with benign defaults
    function automatic access_t mk(input id_reg_t s, input logic r,
        input logic w, input level_t l, input logic w64);
        access_t x;
        x = '0;
        x.valid = 1'b1;
        x.rd = r;
        x.wr = w;
        x.sel = s;
        x.lvl = l;
        x.is64 = w64;
        x.cond_pass = 1'b1;
        x.would_sleep = 1'b1;
        x.os_no_trap = 1'b1;
        x.uct_nonzero = 1'b1;
        return x;
    endfunction : mk

    // Issue one instruction and check all outcomes in its cycle
    task automatic t(input access_t x, input logic h, input logic [5:0] e,
        input logic k, input logic u);
        decoder.issue(x);
        cmp({hyp, ec, kern, undef}, {h, e, k, u}, "trap outcome");
        if (h) begin
            exp_cnt++;
        end
        decoder.drop();
    endtask : t

    // Wait-for-event access with chosen qualifiers
    function automatic access_t wt(input level_t l, input logic w64,
        input logic tmo, input logic pass, input logic slp, input logic ok);
        access_t x;
        x = mk(REG_NONE, 1'b0, 1'b0, l, w64);
        x.wait_for_event_instr = ~tmo;
        x.wait_for_event_timeout_instr = tmo;
        x.cond_pass = pass;
        x.would_sleep = slp;
        x.os_no_trap = ok;
        return x;
    endfunction : wt

    // Final verdict, shared by the main flow and the watchdog
    task automatic print_verdict();
        $display("Compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // Watchdog well beyond the hundred or so cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk_i);
        bad_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        // Controls reset to zero, so enable the four trap controls explicitly
        bus(1'b1, CTRL_OFFSET, 32'h0003_c000, got);
        bus(1'b1, HOST_OFFSET, 32'h0, got);
        $display("Test bus setup done");
        t(mk(REG_CACHE_SIZE_ID, 1, 0, LVL_KERNEL, 1), 1, 6'h18, 0, 0);
        t(mk(REG_CACHE_TYPE, 1, 0, LVL_USER, 1), 1, 6'h18, 0, 0);
        a = mk(REG_CACHE_TYPE, 1, 0, LVL_USER, 1);
        a.uct_nonzero = 1'b0;
        t(a, 0, 6'h00, 1, 0);
        t(mk(REG_CACHE_SIZE_SEL, 0, 1, LVL_KERNEL, 1), 1, 6'h18, 0, 0);
        t(mk(REG_CACHE_SIZE_SEL, 0, 1, LVL_KERNEL, 0), 1, 6'h03, 0, 0);
        t(mk(REG_CACHE_LEVEL, 1, 0, LVL_KERNEL, 0), 1, 6'h03, 0, 0);
        t(mk(REG_MATRIX, 1, 0, LVL_KERNEL, 1), 1, 6'h18, 0, 0);
        t(mk(REG_TLB_TYPE, 1, 0, LVL_KERNEL, 0), 1, 6'h03, 0, 0);
        t(mk(REG_BYTECODE, 1, 0, LVL_KERNEL, 0), 1, 6'h05, 0, 0);
        t(mk(REG_BYTECODE, 1, 0, LVL_USER, 0), 1, 6'h05, 0, 0);
        a = mk(REG_FP_SYSTEM, 1, 0, LVL_KERNEL, 0);
        a.fp_move = 1'b1;
        t(a, 1, 6'h08, 0, 0);
        a.rd = 1'b0;
        a.wr = 1'b1;
        t(a, 0, 6'h00, 0, 0);
        t(mk(REG_FP_SYSTEM, 1, 0, LVL_USER, 0), 0, 6'h00, 0, 1);
        $display("Test id groups done");
        t(wt(LVL_KERNEL, 1, 0, 1, 1, 1), 1, 6'h01, 0, 0);
        t(wt(LVL_USER, 0, 1, 1, 1, 1), 1, 6'h01, 0, 0);
        t(wt(LVL_KERNEL, 1, 0, 1, 0, 1), 0, 6'h00, 0, 0);
        t(wt(LVL_USER, 1, 0, 1, 1, 0), 0, 6'h00, 1, 0);
        t(wt(LVL_KERNEL, 0, 0, 0, 1, 1), 0, 6'h00, 0, 0);
        $display("Test wait done");
        hyp_en <= 1'b0;
        t(mk(REG_CACHE_SIZE_ID, 1, 0, LVL_KERNEL, 1), 0, 6'h00, 0, 0);
        hyp_en <= 1'b1;
        bus(1'b1, HOST_OFFSET, 32'h2, got);
        t(mk(REG_REVISION, 1, 0, LVL_KERNEL, 1), 0, 6'h00, 0, 0);
        t(mk(REG_CACHE_SIZE_ID, 1, 0, LVL_KERNEL, 1), 1, 6'h18, 0, 0);
        bus(1'b1, HOST_OFFSET, 32'h3, got);
        t(mk(REG_CACHE_SIZE_ID, 1, 0, LVL_KERNEL, 1), 0, 6'h00, 0, 0);
        t(wt(LVL_KERNEL, 1, 0, 1, 1, 1), 0, 6'h00, 0, 0);
        bus(1'b0, CTRL_OFFSET, 32'h0, got);
        cmp(got, 32'h0003_c000, "ctrl direct read");
        bus(1'b1, HOST_OFFSET, 32'h0, got);
        bus(1'b1, CTRL_OFFSET, 32'h0, got);
        t(mk(REG_CACHE_SIZE_ID, 1, 0, LVL_KERNEL, 1), 0, 6'h00, 0, 0);
        bus(1'b0, STATUS_OFFSET, 32'h0, got);
        cmp({16'h0, got[31:16]}, exp_cnt, "trap count");
        cmp({16'h0, got[15:0]}, 32'h0000_0018, "last outcome");
        bus(1'b0, 4'hc, 32'h0, got);
        cmp(got, 32'h0, "unmapped read");
        $display("Test masking and status done");
        print_verdict();
    end
endmodule : id_and_wait_trap_decoder_tb
`default_nettype wire
